/* File: src/udr_rom.sv */
// Default full-speed descriptor store: alternate setting 1 endpoints and all of alternate setting 2.
//
// Contract
// - Each endpoint descriptor is seven bytes, starting 07h then type 05h.
// - Each endpoint reports 64-byte max packet: 40h then 00h.
// - Byte order: length, type, address, attributes, size low, size high, interval.
// - Address bit 7 set for IN, clear for OUT; number in low bits.
// - Interval is 00h for bulk endpoints and 0Ah for interrupt endpoints.
// - Setting 2 endpoint 1 OUT: address 01h, interrupt 03h, interval 0Ah.
// - Endpoint 1 IN 81h: bulk in setting 1, interrupt in setting 2.
// - Endpoint 2 OUT 02h: bulk in setting 1, interrupt in setting 2.
// - Endpoint 4 OUT 04h: bulk, interval 00h, in both settings.
// - Endpoint 6 IN 86h: bulk in setting 1, interrupt in setting 2.
// - Endpoint 8 IN 88h: bulk, interval 00h, in both settings.
// - Setting 2 interface carries alternate 02h, followed by its six endpoints.
// - Setting 2 interface reports 06h endpoints, control endpoint excluded.
// - Setting 2 interface is nine bytes: 09h then type 04h.
// - Setting 2 interface number is 00h.
// - Class, subclass and protocol are each FFh.
// - Interface string index is 00h.
// - Bytes stored contiguously in listed order for sequential streaming.
// - Whole configuration block totals 171 bytes, reported ABh 00h.
`timescale 1ns/1ps
`default_nettype none
`include "udr_consts.svh"
module udr_rom (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        req_valid,
  input  wire logic [6:0]  req_start,
  input  wire logic [15:0] req_len,
  input  wire logic        byte_ready,
  output logic             byte_valid,
  output logic [7:0]       byte_data,
  output logic             byte_last,
  output logic             busy,
  output logic [15:0]      total_len
);

  // One endpoint descriptor byte, picked by its offset within the descriptor.
  function automatic logic [7:0] ep_byte(input logic [2:0] off, input logic [7:0] addr, input logic intr);
    unique case (off)
      3'd0:    ep_byte = `UDR_EP_LEN;
      3'd1:    ep_byte = `UDR_EP_TYPE;
      3'd2:    ep_byte = addr;
      3'd3:    ep_byte = intr ? `UDR_ATTR_INT : `UDR_ATTR_BULK;
      3'd4:    ep_byte = `UDR_MPS_LO;
      3'd5:    ep_byte = `UDR_MPS_HI;
      3'd6:    ep_byte = intr ? `UDR_IVL_INT : `UDR_IVL_BULK;
      default: ep_byte = 8'h00;
    endcase
  endfunction : ep_byte

  localparam logic [7:0] EP_ADDR [6] = '{`UDR_ADDR_EP1_OUT, `UDR_ADDR_EP1_IN, `UDR_ADDR_EP2_OUT,
                                         `UDR_ADDR_EP4_OUT, `UDR_ADDR_EP6_IN, `UDR_ADDR_EP8_IN};
  // Interrupt type in setting 2, per endpoint slot; setting 1 is all bulk.
  localparam logic [5:0] ALT2_INT = 6'b010111;
  localparam logic [7:0] IF_BYTES [9] = '{`UDR_IF_LEN, `UDR_IF_TYPE, `UDR_IF_NUM, `UDR_ALT2, `UDR_ALT2_NEP,
                                          `UDR_VENDOR, `UDR_VENDOR, `UDR_VENDOR, `UDR_NO_STRING};

  logic [7:0] rom [`UDR_ROM_DEPTH*2];

  // Contiguous image: six setting 1 endpoints, setting 2 interface, six setting 2 endpoints.
  genvar e, b;
  generate
    for (e = 0; e < 6; e++) begin : g_ep
      for (b = 0; b < 7; b++) begin : g_b
        assign rom[`UDR_ALT1_EP_BASE + e*7 + b] = ep_byte(3'(b), EP_ADDR[e], 1'b0);
        assign rom[`UDR_ALT2_EP_BASE + e*7 + b] = ep_byte(3'(b), EP_ADDR[e], ALT2_INT[e]);
      end
    end
    for (b = 0; b < 9; b++) begin : g_if
      assign rom[`UDR_ALT2_IF_BASE + b] = IF_BYTES[b];
    end
    for (b = `UDR_END; b < `UDR_ROM_DEPTH*2; b++) begin : g_pad
      assign rom[b] = 8'h00;
    end
  endgenerate

  assign total_len = `UDR_TOTAL_LEN;

  udr_pkg::udr_state_t state;
  logic [6:0]  addr;
  logic [15:0] remain;
  logic [6:0]  next_addr;
  logic        last_now;

  // Stop at the stored end or the requested count, whichever comes first.
  assign next_addr = addr + 7'd1;
  assign last_now  = (remain == 16'h0001) || (next_addr == `UDR_END);
  assign busy      = (state == udr_pkg::UDR_SEND);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= udr_pkg::UDR_IDLE;
      addr  <= 7'd0;
      remain <= 16'h0000;
    end else begin
      unique case (state)
        udr_pkg::UDR_IDLE: begin
          if (req_valid && req_len != 16'h0000 && req_start < `UDR_END) begin
            state  <= udr_pkg::UDR_SEND;
            addr   <= req_start;
            remain <= req_len;
          end
        end
        udr_pkg::UDR_SEND: begin
          if (byte_ready) begin
            addr   <= next_addr;
            remain <= remain - 16'h0001;
            if (last_now) begin
              state <= udr_pkg::UDR_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      byte_data <= 8'h00;
      byte_last <= 1'b0;
    end else begin
      byte_data <= rom[addr];
      // Only the accepted final step is flagged, so a stalled consumer never sees an early last.
      byte_last <= last_now && busy && byte_ready;
    end
  end

  // Data is registered one cycle after the address, so valid trails busy by one cycle.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      byte_valid <= 1'b0;
    end else begin
      byte_valid <= busy;
    end
  end

  rom_ep1_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT1_EP_BASE] == `UDR_EP_LEN && rom[`UDR_ALT1_EP_BASE + 1] == `UDR_EP_TYPE)
    else $error("Endpoint header bytes wrong.");
  rom_mps_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT2_EP_BASE + 4] == 8'h40 && rom[`UDR_ALT2_EP_BASE + 5] == 8'h00)
    else $error("Max packet size wrong.");
  alt2_int_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT2_EP_BASE + 3] == 8'h03 && rom[`UDR_ALT2_EP_BASE + 6] == 8'h0a)
    else $error("Setting 2 endpoint 1 OUT wrong.");
  alt1_bulk_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT1_EP_BASE + 7 + 2] == 8'h81 && rom[`UDR_ALT1_EP_BASE + 7 + 3] == 8'h02)
    else $error("Setting 1 endpoint 1 IN wrong.");
  if_hdr_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT2_IF_BASE + 3] == 8'h02 && rom[`UDR_ALT2_IF_BASE + 4] == 8'h06)
    else $error("Setting 2 interface header wrong.");
  ep8_bulk_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT2_EP_BASE + 35 + 3] == 8'h02 && rom[`UDR_ALT2_EP_BASE + 35 + 6] == 8'h00)
    else $error("Endpoint 8 not bulk.");
  send_start_a: assert property (@(posedge clock) disable iff (!resetn)
    (!busy && req_valid && req_len != 16'h0000 && req_start < `UDR_END) |=> busy ##1 byte_valid)
    else $error("Request did not start a stream.");
  stop_len_a: assert property (@(posedge clock) disable iff (!resetn)
    (busy && byte_ready && last_now) |=> !busy)
    else $error("Stream did not stop at its length.");
  last_flag_a: assert property (@(posedge clock) disable iff (!resetn)
    (busy && byte_ready && last_now) |=> (byte_valid && byte_last))
    else $error("Final byte not flagged.");
  in_dir_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT1_EP_BASE + 9][`UDR_IN_BIT] == 1'b1 && rom[`UDR_ALT1_EP_BASE + 2][`UDR_IN_BIT] == 1'b0)
    else $error("Endpoint direction bit wrong.");
  ep6_int_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT2_EP_BASE + 30] == 8'h86 && rom[`UDR_ALT2_EP_BASE + 31] == 8'h03)
    else $error("Setting 2 endpoint 6 IN wrong.");
  if_len_a: assert property (@(posedge clock) disable iff (!resetn)
    rom[`UDR_ALT2_IF_BASE] == 8'h09 && rom[`UDR_ALT2_IF_BASE + 1] == 8'h04
    && rom[`UDR_ALT2_IF_BASE + 5] == 8'hff)
    else $error("Setting 2 interface length or class wrong.");
  one_cov: cover property (@(posedge clock) disable iff (!resetn) busy && req_len == 16'h0001);
  end_cov: cover property (@(posedge clock) disable iff (!resetn) busy && next_addr == `UDR_END);
  stall_cov: cover property (@(posedge clock) disable iff (!resetn) byte_valid && !byte_ready);

endmodule : udr_rom
`default_nettype wire

/* File: inc/udr_consts.svh */
// Constants for the default descriptor store.
`ifndef UDR_CONSTS_SVH
`define UDR_CONSTS_SVH
`define UDR_EP_LEN        8'h07
`define UDR_EP_TYPE       8'h05
`define UDR_IF_LEN        8'h09
`define UDR_IF_TYPE       8'h04
`define UDR_MPS_LO        8'h40
`define UDR_MPS_HI        8'h00
`define UDR_ATTR_BULK     8'h02
`define UDR_ATTR_INT      8'h03
`define UDR_IVL_BULK      8'h00
`define UDR_IVL_INT       8'h0a
`define UDR_IN_BIT        7
`define UDR_VENDOR        8'hff
`define UDR_NO_STRING     8'h00
`define UDR_IF_NUM        8'h00
`define UDR_ALT2          8'h02
`define UDR_ALT2_NEP      8'h06
`define UDR_ADDR_EP1_OUT  8'h01
`define UDR_ADDR_EP1_IN   8'h81
`define UDR_ADDR_EP2_OUT  8'h02
`define UDR_ADDR_EP4_OUT  8'h04
`define UDR_ADDR_EP6_IN   8'h86
`define UDR_ADDR_EP8_IN   8'h88
`define UDR_ROM_DEPTH     64
`define UDR_ALT1_EP_BASE  7'd0
`define UDR_ALT2_IF_BASE  7'd42
`define UDR_ALT2_EP_BASE  7'd51
`define UDR_TOTAL_LEN     16'h00ab
`define UDR_END           7'd93
`endif

/* File: inc/udr_pkg.sv */
// Types for the default descriptor store.
package udr_pkg;
  typedef enum logic {UDR_IDLE, UDR_SEND} udr_state_t;
endpackage : udr_pkg

/* File: bench/udr_host_model.sv */
// Host-side consumer that accepts streamed descriptor bytes, at full rate or with stalls.
`timescale 1ns/1ps
`default_nettype none
module udr_host_model (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       slow,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_last,
  output logic            byte_ready
);
  logic       ready_d;
  logic [1:0] phase;
  logic [7:0] got[$];
  int         lasts;
  int         last_pos;
  // A byte belongs to the address step accepted one cycle earlier.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase    <= 2'h0;
      ready_d  <= 1'b0;
      lasts    <= 0;
      last_pos <= 0;
    end else begin
      phase   <= phase + 2'h1;
      ready_d <= byte_ready;
      if (byte_valid && ready_d) begin
        got.push_back(byte_data);
        if (byte_last) begin
          lasts    <= lasts + 1;
          last_pos <= got.size();
        end
      end
    end
  end
  assign byte_ready = !slow || (phase == 2'h3);
endmodule : udr_host_model
`default_nettype wire

/* File: bench/udr_rom_tb_top.sv */
// Self-checking bench for the default descriptor store.
`timescale 1ns/1ps
`default_nettype none
module udr_rom_tb_top;
  typedef struct {logic [6:0] st; logic [15:0] ln; logic sl;} udr_row_t;
  logic clock = 1'b0, resetn = 1'b0, req_valid = 1'b0, slow = 1'b0, byte_ready;
  logic [6:0] req_start = 7'h00;
  logic [15:0] req_len = 16'h0000, total_len;
  logic byte_valid, byte_last, busy;
  logic [7:0] byte_data, rom[$];
  logic [7:0] ad[6] = '{8'h01, 8'h81, 8'h02, 8'h04, 8'h86, 8'h88};
  udr_row_t rows[6] = '{'{7'h07, 16'h0007, 1'b0}, '{7'h2a, 16'h0009, 1'b1}, '{7'h33, 16'h002a, 1'b0},
                        '{7'h00, 16'hffff, 1'b1}, '{7'h2a, 16'h0003, 1'b0}, '{7'h5c, 16'h0005, 1'b0}};
  int mismatches = 0, comparisons = 0, n, k, l0;
  udr_rom udr_rom_i (.clock(clock), .resetn(resetn), .req_valid(req_valid), .req_start(req_start),
    .req_len(req_len), .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_last(byte_last), .busy(busy), .total_len(total_len));
  udr_host_model udr_host_model_i (.clock(clock), .resetn(resetn), .slow(slow), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_last(byte_last), .byte_ready(byte_ready));
  initial forever #5 clock = ~clock;
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk8
  task automatic chk16(string nm, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk16
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic run(logic [6:0] st, logic [15:0] ln);
    int i;
    udr_host_model_i.got.delete();
    @(posedge clock);
    #1 req_valid = 1'b1;
    req_start = st;
    req_len = ln;
    @(posedge clock);
    #1 req_valid = 1'b0;
    repeat (2) @(posedge clock);
    for (i = 0; i < 2000 && busy === 1'b1; i++) @(posedge clock);
    if (i == 2000) begin
      mismatches++;
      give_verdict();
    end
    repeat (3) @(posedge clock);
  endtask : run
  initial begin
    for (int s = 1; s < 3; s++) begin
      if (s == 2) foreach (ad[j]) rom.push_back(j < 2 ? 8'h09 : 8'h04);
      if (s == 2) {rom[42], rom[43]} = {8'h09, 8'h04};
      if (s == 2) rom = {rom[0:43], 8'h00, 8'h02, 8'h06, 8'hff, 8'hff, 8'hff, 8'h00};
      foreach (ad[j]) begin
        k = (s == 2 && j != 3 && j != 5);
        rom = {rom, 8'h07, 8'h05, ad[j], k ? 8'h03 : 8'h02, 8'h40, 8'h00, k ? 8'h0a : 8'h00};
      end
    end
    repeat (6) @(posedge clock);
    #1 resetn = 1'b1;
    chk16("total_len", 16'h00ab, total_len);
    foreach (rows[r]) begin
      slow = rows[r].sl;
      l0 = udr_host_model_i.lasts;
      run(rows[r].st, rows[r].ln);
      chk16("last flags", 16'h0001, 16'(udr_host_model_i.lasts - l0));
      n = rom.size() - rows[r].st;
      if (rows[r].ln < n) n = rows[r].ln;
      chk16("count", n[15:0], udr_host_model_i.got.size());
      chk16("last position", n[15:0], 16'(udr_host_model_i.last_pos));
      for (int i = 0; i < n && i < udr_host_model_i.got.size(); i++)
        chk8("byte", rom[rows[r].st + i], udr_host_model_i.got[i]);
      $display("row %0d done", r);
    end
    run(7'h00, 16'h0000);
    chk16("zero length count", 16'h0000, udr_host_model_i.got.size());
    run(7'h64, 16'h0004);
    chk16("past end count", 16'h0000, udr_host_model_i.got.size());
    $display("refusal test done");
    @(posedge clock);
    #1 req_valid = 1'b1;
    req_start = 7'h00;
    req_len = 16'h0050;
    @(posedge clock);
    #1 req_valid = 1'b0;
    repeat (8) @(posedge clock);
    #1 resetn = 1'b0;
    #1 chk8("reset outputs", 8'h00, {5'h00, busy, byte_valid, byte_last});
    @(posedge clock);
    #1 resetn = 1'b1;
    slow = 1'b0;
    run(7'h2a, 16'h0009);
    chk16("after reset count", 16'h0009, udr_host_model_i.got.size());
    if (udr_host_model_i.got.size() > 0)
      chk8("after reset first", rom[42], udr_host_model_i.got[0]);
    $display("reset test done");
    give_verdict();
  end
endmodule : udr_rom_tb_top
`default_nettype wire
